/* File: hw/level_sync.sv */
/*
 * Two-flop synchroniser bank for levels arriving from outside pclk.
 * Assumes each bit is a slow level; pulses shorter than one cycle may be lost.
 */
module level_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : level_sync

/* File: hw/reset_source_and_sleep_domain_ctrl.sv */
/*
 * Central reset source handling and deep-sleep power domain control,
 * with watchdog, cause recording and an APB register file.
 * Assumes pclk at 20 MHz from the always-on domain, presetn from the
 * power-on detector, and same-clock option-byte loader handshake.
 */
// The APB register port and the address map were left to the implementer.
//
// Notes on behaviour
// R01: All sources merge into one reset decision; the TAP pin drives tap_reset on its own
// R02: Watchdog counts 1 kHz ticks, expiry resets
// R03: CPU request becomes software reset source
// R04: Option byte check failure raises reset
// R05: Retry option load while failures below three
// R06: Third failure stops, enters emulated sleep
// R07: Readout protection forced during that sleep
// R08: Debugger request becomes debug reset source
// R09: TAP reset pin resets only TAP
// R10: TAP pin ignored in serial-wire or disabled
// R11: Sleep entry and exit signal reset generation
// R12: Sleep reset held until low-voltage detect good
// R13: Emulated sleep keeps memory and core powered
// R14: Always-on domain never powered down
// R15: Core domain off in deep sleep
// R16: RAM fed from always-on supply in deep sleep
// R17: Flash fully unpowered in deep sleep
// R18: Open-drain regulator enable, can be disabled
// R19: Last reset cause recorded for software; debugger resets leave the cause unchanged
// R20: Async sources synchronised, release clock-synchronous
module reset_source_and_sleep_domain_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic clk1k_ref,
  input wire logic cpu_soft_reset_req,
  input wire logic opt_check_done,
  input wire logic config_byte_check_fail_src,
  input wire logic debugger_reset_req,
  input wire logic tap_only_reset_pin,
  input wire logic serial_wire_mode,
  input wire logic serial_jtag_debug_port_en,
  input wire logic low_voltage_power_on_detect,
  input wire logic wake_req,
  output rst_sleep_pkg::rst_out_s rst_out,
  output logic tap_reset,
  output rst_sleep_pkg::pwr_out_s pwr_out,
  output logic readout_protect_forced,
  output logic reg_en_o,
  output logic reg_en_oe
);
  import rst_sleep_pkg::*;

  ctl_state_s st_r;
  ctl_state_s st_nxt;
  logic [4:0] sync_q;
  logic clk1k_q;
  logic dbg_q;
  logic tap_q;
  logic lv_q;
  logic wake_q;
  logic jtag_ok;
  logic wd_tick;
  logic wd_fire;
  logic opt_fail;
  logic lv_drop;
  logic setup_ph;
  logic access_ph;
  logic mapped;
  logic [4:0] new_mask;
  logic emu_sel;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  level_sync #(.W(5)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({clk1k_ref, debugger_reset_req, tap_only_reset_pin,
        low_voltage_power_on_detect, wake_req}),
    .q(sync_q)
  ); // [R20]

  assign {clk1k_q, dbg_q, tap_q, lv_q, wake_q} = sync_q;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == CTRL_OFS) || (a == STATUS_OFS) || (a == WDOG_LOAD_OFS)
      || (a == WDOG_KICK_OFS) || (a == CAUSE_OFS);
  endfunction : is_mapped

  function automatic logic [7:0] cause_of(input int bitpos);
    cause_of = CAUSE_RST | (8'h01 << bitpos);
  endfunction : cause_of

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign mapped = is_mapped(paddr);
  assign jtag_ok = serial_jtag_debug_port_en && !serial_wire_mode;
  assign wd_tick = clk1k_q && !st_r.clk1k_d;
  assign wd_fire = wd_tick && st_r.ctrl[CTRL_WD_EN] && (st_r.wd_cnt == 16'h0000);
  assign opt_fail = opt_check_done && config_byte_check_fail_src;
  assign lv_drop = st_r.lv_d && !lv_q && (st_r.state == ST_RUN);
  assign emu_sel = st_r.ctrl[CTRL_SLEEP_EMU] || st_r.emu_lock;

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    st_nxt = st_r;
    new_mask = MASK_NONE;
    st_nxt.clk1k_d = clk1k_q;
    st_nxt.lv_d = lv_q;
    st_nxt.ctrl[CTRL_SLEEP_GO] = 1'b0;
    // TAP reset stands apart from every other source
    st_nxt.tap_rst = tap_q && jtag_ok; // [R09] [R10]

    // Watchdog on the 1 kHz reference
    if (wd_tick && st_r.ctrl[CTRL_WD_EN]) begin
      st_nxt.wd_cnt = (st_r.wd_cnt == 16'h0000) ? st_r.wd_load
        : st_r.wd_cnt - 16'h0001; // [R02]
    end

    // Register writes
    if (access_ph && pwrite) begin
      case (paddr)
        CTRL_OFS: begin
          st_nxt.ctrl = pwdata[4:0];
        end
        WDOG_LOAD_OFS: begin
          st_nxt.wd_load = pwdata[15:0];
        end
        WDOG_KICK_OFS: begin
          if (pwdata == WDOG_KICK_KEY) begin
            st_nxt.wd_cnt = st_r.wd_load;
          end
        end
        CAUSE_OFS: begin
          st_nxt.cause = CAUSE_RST;
        end
        default: begin
        end
      endcase
    end

    // Read data captured in the setup phase
    if (setup_ph) begin
      case (paddr)
        CTRL_OFS: st_nxt.prdata = {27'h0, st_r.ctrl};
        STATUS_OFS: st_nxt.prdata = {st_r.wd_cnt, 5'h00, st_r.tap_rst,
          readout_protect_forced, st_r.emu_lock, st_r.fail_cnt, st_r.state};
        WDOG_LOAD_OFS: st_nxt.prdata = {16'h0000, st_r.wd_load};
        CAUSE_OFS: st_nxt.prdata = {24'h000000, st_r.cause}; // [R19]
        default: st_nxt.prdata = 32'h0000_0000;
      endcase
    end

    // Pulse countdown, release on a clock edge
    if (st_r.rst_cnt != 4'h0) begin
      st_nxt.rst_cnt = st_r.rst_cnt - 4'h1;
    end else if (st_r.state == ST_RUN) begin
      st_nxt.rst_mask = MASK_NONE; // [R20]
    end

    case (st_r.state)
      ST_RUN: begin
        // All run-time sources but the TAP pin merge here; masks accumulate
        if (lv_drop) begin
          new_mask = MASK_LV_RUN;
          st_nxt.cause = cause_of(CAUSE_LV);
        end else if (wd_fire) begin
          new_mask = MASK_WDOG; // [R02]
          st_nxt.cause = cause_of(CAUSE_WDOG);
        end else if (cpu_soft_reset_req) begin
          new_mask = MASK_SW; // [R03]
          st_nxt.cause = cause_of(CAUSE_SW);
        end
        if (opt_fail) begin
          st_nxt.cause[CAUSE_OPT] = 1'b1; // [R19]
          if (st_r.fail_cnt + 2'h1 < OPT_FAIL_LIMIT) begin
            st_nxt.fail_cnt = st_r.fail_cnt + 2'h1;
            new_mask = new_mask | MASK_OPT; // [R04] [R05]
          end else begin
            st_nxt.fail_cnt = OPT_FAIL_LIMIT;
            st_nxt.emu_lock = 1'b1; // [R06]
            st_nxt.state = ST_SLEEP;
            st_nxt.rst_mask = MASK_EMU;
          end
        end else if (opt_check_done) begin
          st_nxt.fail_cnt = 2'h0;
        end
        if (dbg_q) begin
          new_mask = new_mask | MASK_DBG; // [R08]
        end
        if (new_mask != MASK_NONE && !st_nxt.emu_lock) begin
          st_nxt.rst_mask = st_r.rst_mask | new_mask; // [R01]
          st_nxt.rst_cnt = RST_CYCLES;
        end else if (st_r.ctrl[CTRL_SLEEP_GO] && !st_nxt.emu_lock) begin
          st_nxt.state = ST_ENTER; // [R11]
          st_nxt.rst_mask = emu_sel ? MASK_EMU : MASK_DSLEEP; // [R12]
        end
      end
      ST_ENTER: begin
        st_nxt.state = emu_sel ? ST_SLEEP : ST_PWROFF; // [R13]
      end
      ST_PWROFF: begin
        st_nxt.state = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (wake_q) begin
          st_nxt.state = ST_WAKE; // [R11]
        end
      end
      ST_WAKE: begin
        st_nxt.state = ST_PWRUP;
      end
      ST_PWRUP: begin
        // Held until the low-voltage detector reports good levels
        if (lv_q) begin
          st_nxt.state = ST_RUN; // [R12]
          st_nxt.rst_cnt = RST_CYCLES;
          st_nxt.cause = cause_of(CAUSE_WAKE); // [R19]
          st_nxt.emu_lock = 1'b0;
          st_nxt.fail_cnt = 2'h0;
        end
      end
      default: begin
        st_nxt.state = ST_RUN;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.state <= ST_RUN;
      st_r.rst_mask <= MASK_NONE;
      st_r.rst_cnt <= 4'h0;
      st_r.fail_cnt <= 2'h0;
      st_r.emu_lock <= 1'b0;
      st_r.cause <= CAUSE_RST;
      st_r.wd_cnt <= WDOG_LOAD_RST;
      st_r.wd_load <= WDOG_LOAD_RST;
      st_r.ctrl <= 5'h00;
      st_r.clk1k_d <= 1'b0;
      st_r.lv_d <= 1'b0;
      st_r.tap_rst <= 1'b0;
      st_r.prdata <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign pready = 1'b1;
  assign pslverr = access_ph && !mapped;
  assign prdata = st_r.prdata;
  assign rst_out = st_r.rst_mask; // [R01]
  assign tap_reset = st_r.tap_rst; // [R09]
  assign readout_protect_forced = st_r.emu_lock || st_r.ctrl[CTRL_RDP_CFG]; // [R07]

  // Power off only in the non-emulated deep states
  always_comb begin
    logic deep;
    deep = 1'b0;
    deep = !emu_sel && (st_r.state == ST_PWROFF || st_r.state == ST_SLEEP
      || st_r.state == ST_WAKE);
    pwr_out.core_on = !deep; // [R13] [R15]
    pwr_out.flash_on = !deep; // [R17]
    pwr_out.ram_from_aon = deep; // [R16]
    pwr_out.aon_on = 1'b1; // [R14]
  end

  // Pull-up keeps regulators on; pull low to switch them off
  assign reg_en_o = 1'b0;
  assign reg_en_oe = !st_r.ctrl[CTRL_REGEN_DIS] && !pwr_out.core_on; // [R18]

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  tap_gate_a: assert property ((tap_q && jtag_ok) |=> tap_reset && !rst_out.sys) // [R09]
    else $error("tap reset not following pin");
  tap_block_a: assert property (!jtag_ok |=> !tap_reset) // [R10]
    else $error("tap reset while debug mode blocks it");
  wdog_fire_a: assert property ((wd_fire && st_r.state == ST_RUN && !lv_drop
      && !opt_fail) |=> rst_out.sys && !rst_out.dap && st_r.cause[CAUSE_WDOG]) // [R02]
    else $error("watchdog expiry did not reset");
  sw_reset_a: assert property ((cpu_soft_reset_req && st_r.state == ST_RUN && !st_r.emu_lock)
      |=> rst_out.sys && rst_out.periph_aon) // [R03]
    else $error("software reset lost");
  dbg_reset_a: assert property ((dbg_q && st_r.state == ST_RUN && !opt_fail)
      |=> rst_out.sys[*2]) // [R08]
    else $error("debug reset lost");
  opt_third_a: assert property ((opt_fail && st_r.fail_cnt == 2'h2 && st_r.state == ST_RUN)
      |=> st_r.emu_lock && st_r.state == ST_SLEEP && pwr_out.core_on) // [R06]
    else $error("third option failure not handled");
  opt_retry_a: assert property ((opt_fail && st_r.fail_cnt == 2'h0 && st_r.state == ST_RUN)
      |=> rst_out.por && !st_r.emu_lock && st_r.fail_cnt == 2'h1) // [R05]
    else $error("option retry wrong");
  rdp_force_a: assert property (st_r.emu_lock |-> readout_protect_forced) // [R07]
    else $error("readout protection not forced");
  sleep_rst_a: assert property ((st_r.state != ST_RUN) |-> rst_out.sys && rst_out.periph_core) // [R12]
    else $error("sleep reset dropped");
  pwrup_hold_a: assert property ((st_r.state == ST_PWRUP && !lv_q) |=> st_r.state == ST_PWRUP) // [R12]
    else $error("left power-up before detector");
  deep_pwr_a: assert property ((st_r.state == ST_SLEEP && !emu_sel)
      |-> !pwr_out.core_on && !pwr_out.flash_on && pwr_out.ram_from_aon) // [R15]
    else $error("deep sleep power wrong");
  unmapped_a: assert property ((access_ph && !mapped) |-> pslverr && pready)
    else $error("unmapped access not flagged");

endmodule : reset_source_and_sleep_domain_ctrl

/* File: hw/rst_sleep_pkg.sv */
/*
 * Constants, register map and state carriers for the reset source and
 * sleep domain controller.
 * Assumes a 32-bit APB slave on pclk and active-high internal resets.
 */
package rst_sleep_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] WDOG_LOAD_OFS = 8'h08;
  localparam logic [7:0] WDOG_KICK_OFS = 8'h0C;
  localparam logic [7:0] CAUSE_OFS = 8'h10;

  // Control bit positions
  localparam int CTRL_WD_EN = 0;
  localparam int CTRL_SLEEP_GO = 1;
  localparam int CTRL_SLEEP_EMU = 2;
  localparam int CTRL_REGEN_DIS = 3;
  localparam int CTRL_RDP_CFG = 4;

  // Cause bit positions
  localparam int CAUSE_HV = 0;
  localparam int CAUSE_LV = 1;
  localparam int CAUSE_WDOG = 3;
  localparam int CAUSE_SW = 4;
  localparam int CAUSE_WAKE = 5;
  localparam int CAUSE_OPT = 6;
  localparam logic [7:0] CAUSE_RST = 8'h01;

  localparam logic [31:0] WDOG_KICK_KEY = 32'h0000_A5A5;
  localparam logic [15:0] WDOG_LOAD_RST = 16'h0800;
  localparam logic [1:0] OPT_FAIL_LIMIT = 2'h3;

  // Least length of a generated reset pulse
  localparam int unsigned RST_PULSE_NS = 400;
  localparam int unsigned RST_CYCLES_I = (RST_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0] RST_CYCLES = 4'(RST_CYCLES_I);

  // Reset masks: {por, sys, dap, periph_aon, periph_core}
  localparam logic [4:0] MASK_NONE = 5'h00;
  localparam logic [4:0] MASK_LV_RUN = 5'h1F;
  localparam logic [4:0] MASK_WDOG = 5'h0B;
  localparam logic [4:0] MASK_SW = 5'h0B;
  localparam logic [4:0] MASK_OPT = 5'h19;
  localparam logic [4:0] MASK_DSLEEP = 5'h1D;
  localparam logic [4:0] MASK_EMU = 5'h09;
  localparam logic [4:0] MASK_DBG = 5'h08;

  typedef enum logic [5:0] {
    ST_RUN = 6'h01,
    ST_ENTER = 6'h02,
    ST_PWROFF = 6'h04,
    ST_SLEEP = 6'h08,
    ST_WAKE = 6'h10,
    ST_PWRUP = 6'h20
  } slp_state_e;

  typedef struct packed {
    logic por;
    logic sys;
    logic dap;
    logic periph_aon;
    logic periph_core;
  } rst_out_s;

  typedef struct packed {
    logic core_on;
    logic flash_on;
    logic ram_from_aon;
    logic aon_on;
  } pwr_out_s;

  typedef struct packed {
    slp_state_e state;
    logic [4:0] rst_mask;
    logic [3:0] rst_cnt;
    logic [1:0] fail_cnt;
    logic emu_lock;
    logic [7:0] cause;
    logic [15:0] wd_cnt;
    logic [15:0] wd_load;
    logic [4:0] ctrl;
    logic clk1k_d;
    logic lv_d;
    logic tap_rst;
    logic [31:0] prdata;
  } ctl_state_s;

endpackage : rst_sleep_pkg

/* File: tb/far_side_model.sv */
/*
 * Far side model: 1 kHz reference and option byte loader.
 * Assumes pclk domain; start is a one-cycle pulse from the bench.
 */
module far_side_model #(
  parameter int HALF = 10000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic fail_mode,
  input wire logic sys_rst,
  output logic clk1k_ref,
  output logic opt_check_done,
  output logic config_byte_check_fail_src
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  logic sys_d;
  wire go = start || (sys_d && !sys_rst);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      clk1k_ref <= 1'b0;
      sys_d <= 1'b0;
      opt_check_done <= 1'b0;
      config_byte_check_fail_src <= 1'b0;
    end else begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) clk1k_ref <= !clk1k_ref;
      sys_d <= sys_rst;
      // Loader rechecks on every restart
      opt_check_done <= go;
      // Flag wiggles when not qualified, so a stale value is never seen
      config_byte_check_fail_src <= go ? fail_mode : !config_byte_check_fail_src;
    end
  end
endmodule : far_side_model

/* File: tb/reset_source_and_sleep_domain_ctrl_tb.sv */
/*
 * Self-checking bench for the reset and sleep domain controller.
 * Assumes the far side model; reference clock sped up to keep runs short.
 */
module reset_source_and_sleep_domain_ctrl_tb import rst_sleep_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, pslverr, serr, clk1k_ref, opt_done, cfg_fail;
  logic cpu_req = 0, dbg_req = 0, tap_pin = 0, swmode = 0, dp_en = 1, lv = 1, wake = 0;
  logic start = 0, fail_mode = 0, tap_reset, rp_forced, reg_en_o, reg_en_oe;
  rst_out_s rst_out;
  pwr_out_s pwr_out;
  int bad_count = 0, checked = 0;

  always #25 pclk = ~pclk;

  reset_source_and_sleep_domain_ctrl u_reset_source_and_sleep_domain_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .clk1k_ref(clk1k_ref), .cpu_soft_reset_req(cpu_req), .opt_check_done(opt_done),
    .config_byte_check_fail_src(cfg_fail), .debugger_reset_req(dbg_req),
    .tap_only_reset_pin(tap_pin), .serial_wire_mode(swmode),
    .serial_jtag_debug_port_en(dp_en), .low_voltage_power_on_detect(lv), .wake_req(wake),
    .rst_out(rst_out), .tap_reset(tap_reset), .pwr_out(pwr_out),
    .readout_protect_forced(rp_forced), .reg_en_o(reg_en_o), .reg_en_oe(reg_en_oe)
  );

  far_side_model #(.HALF(40)) u_far_side_model (
    .pclk(pclk), .presetn(presetn), .start(start), .fail_mode(fail_mode),
    .sys_rst(rst_out.sys), .clk1k_ref(clk1k_ref), .opt_check_done(opt_done),
    .config_byte_check_fail_src(cfg_fail)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask : cyc

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      end_of_test();
    end
  endtask : apb

  // Bounded wait for a reset mask, then compared
  task automatic wait_rst(input logic [4:0] exp, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (rst_out !== exp && n < lim);
    chk(32'(rst_out), 32'(exp));
    if (n >= lim) end_of_test();
  endtask : wait_rst

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(32'(pwr_out), 32'hD);
    apb(1'b0, CAUSE_OFS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd & 32'h3F, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    chk(32'(serr), 32'h1);
  endtask : t_reset

  task automatic t_sw();
    @(posedge pclk) cpu_req <= 1'b1;
    @(posedge pclk) cpu_req <= 1'b0;
    wait_rst(5'h0B, 3);
    apb(1'b0, CAUSE_OFS, 32'h0);
    chk(rd, 32'h11);
    wait_rst(5'h00, 30);
  endtask : t_sw

  task automatic t_dbg();
    apb(1'b1, CAUSE_OFS, 32'h0);
    @(posedge pclk) dbg_req <= 1'b1;
    wait_rst(5'h08, 6);
    @(posedge pclk) dbg_req <= 1'b0;
    wait_rst(5'h00, 40);
    apb(1'b0, CAUSE_OFS, 32'h0);
    chk(rd, 32'h1);
  endtask : t_dbg

  task automatic t_tap();
    @(posedge pclk) tap_pin <= 1'b1;
    cyc(5);
    chk(32'(tap_reset), 32'h1);
    chk(32'(rst_out), 32'h0);
    @(posedge pclk) swmode <= 1'b1;
    cyc(5);
    chk(32'(tap_reset), 32'h0);
    @(posedge pclk) begin
      swmode <= 1'b0;
      dp_en <= 1'b0;
    end
    cyc(5);
    chk(32'(tap_reset), 32'h0);
    @(posedge pclk) tap_pin <= 1'b0;
    @(posedge pclk) dp_en <= 1'b1;
  endtask : t_tap

  task automatic t_wdog();
    apb(1'b1, CAUSE_OFS, 32'h0);
    apb(1'b1, WDOG_LOAD_OFS, 32'h1);
    apb(1'b1, WDOG_KICK_OFS, WDOG_KICK_KEY);
    apb(1'b1, CTRL_OFS, 32'h1);
    wait_rst(5'h0B, 400);
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b0, CAUSE_OFS, 32'h0);
    chk(rd, 32'h9);
    wait_rst(5'h00, 40);
  endtask : t_wdog

  task automatic t_opt();
    @(posedge pclk) begin
      fail_mode <= 1'b1;
      start <= 1'b1;
    end
    @(posedge pclk) start <= 1'b0;
    wait_rst(5'h19, 5);
    wait_rst(5'h09, 200);
    chk(32'(rp_forced), 32'h1);
    chk(32'(pwr_out), 32'hD);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd & 32'h1FF, 32'h1C8);
    apb(1'b0, CAUSE_OFS, 32'h0);
    chk(rd & 32'h40, 32'h40);
    @(posedge pclk) begin
      fail_mode <= 1'b0;
      wake <= 1'b1;
    end
    wait_rst(5'h00, 60);
    @(posedge pclk) wake <= 1'b0;
    apb(1'b0, CAUSE_OFS, 32'h0);
    chk(rd, 32'h21);
  endtask : t_opt

  task automatic t_sleep();
    apb(1'b1, CTRL_OFS, 32'h2);
    wait_rst(5'h1D, 3);
    cyc(3);
    chk(32'(pwr_out), 32'h3);
    chk(32'(reg_en_oe), 32'h1);
    chk(32'(reg_en_o), 32'h0);
    @(posedge pclk) begin
      lv <= 1'b0;
      wake <= 1'b1;
    end
    cyc(20);
    chk(32'(rst_out), 32'h1D);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd & 32'h3F, 32'h20);
    @(posedge pclk) begin
      lv <= 1'b1;
      wake <= 1'b0;
    end
    wait_rst(5'h00, 40);
    chk(32'(pwr_out), 32'hD);
    chk(32'(reg_en_oe), 32'h0);
    apb(1'b0, CAUSE_OFS, 32'h0);
    chk(rd, 32'h21);
  endtask : t_sleep

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_sw();
    t_dbg();
    t_tap();
    t_wdog();
    t_opt();
    t_sleep();
    end_of_test();
  end
endmodule : reset_source_and_sleep_domain_ctrl_tb
